// File: core/sched_consts.svh
/*
  Widths, counts and reset values of the exercise-run scheduler.
  Assumes it is included by bare name from files under core/.
*/
`ifndef SCHED_CONSTS_SVH
`define SCHED_CONSTS_SVH

`define SCHED_ENTRIES 16
`define SCHED_IDX_W 4
`define SCHED_DAY_W 5
`define SCHED_MIN_W 11
`define SCHED_DUR_W 16
`define SCHED_WEEK_DAYS 5'h07
`define SCHED_CYCLE_DAYS 5'h1C
`define SCHED_MINS_PER_DAY 11'h5A0
`define SCHED_REM_RST 16'h0000
`define SCHED_DAY_RST 5'h00
`define SCHED_MIN_RST 11'h000
`define SCHED_MASK_RST 16'h0000

`endif

// File: core/sched_pkg.sv
/*
  Types and shared decode for the exercise-run scheduler.
  Assumes sched_consts.svh is on the include path.
*/
`include "sched_consts.svh"

package sched_pkg;

  typedef enum logic [1:0] {
    MODE_STOP = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_AUTO = 2'h2
  } mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RUN = 3'h2,
    ST_STOP = 3'h4
  } run_state_e;

  typedef logic [`SCHED_DAY_W-1:0] day_t;
  typedef logic [`SCHED_MIN_W-1:0] min_t;
  typedef logic [`SCHED_DUR_W-1:0] dur_t;

  // Day match: four-week cycle compares directly, weekly cycle folds the day count
  function automatic logic day_hit(input day_t entry_day, input day_t cur_day,
                                   input logic cycle_28);
    day_t folded;
    folded = cur_day % `SCHED_WEEK_DAYS;
    if (cycle_28) begin
      day_hit = (entry_day == cur_day);
    end else begin
      day_hit = (entry_day == folded);
    end
  endfunction

endpackage

// File: core/sched_entry.sv
/*
  One schedule entry: stored start day, start minute and run length,
  plus the countdown of its run window in calendar minutes.
  Assumes tick_i is a one-cycle pulse once per calendar minute.
*/
`timescale 1ns/1ps
`include "sched_consts.svh"

module sched_entry
  import sched_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic wr_valid_i,
  input wire logic [`SCHED_DAY_W-1:0] wr_day_i,
  input wire logic [`SCHED_MIN_W-1:0] wr_min_i,
  input wire logic [`SCHED_DUR_W-1:0] wr_dur_i,
  input wire logic tick_i,
  input wire logic [`SCHED_DAY_W-1:0] cur_day_i,
  input wire logic [`SCHED_MIN_W-1:0] cur_min_i,
  input wire logic cycle_28_i,
  output logic active_o
);

  logic valid_reg;
  day_t day_reg;
  min_t min_reg;
  dur_t dur_reg;
  dur_t rem_reg;
  logic due;

  assign due = valid_reg && (min_reg == cur_min_i) &&
               day_hit(day_reg, cur_day_i, cycle_28_i);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      valid_reg <= 1'b0;
      day_reg <= `SCHED_DAY_RST;
      min_reg <= `SCHED_MIN_RST;
      dur_reg <= `SCHED_REM_RST;
    end else if (ce_i && wr_i) begin
      valid_reg <= wr_valid_i;
      day_reg <= wr_day_i;
      min_reg <= wr_min_i;
      dur_reg <= wr_dur_i;
    end
  end

  // Rewriting an entry abandons its current window
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rem_reg <= `SCHED_REM_RST;
    end else if (ce_i) begin
      if (wr_i) begin
        rem_reg <= `SCHED_REM_RST;
      end else if (tick_i && due) begin
        rem_reg <= dur_reg;
      end else if (tick_i && rem_reg != `SCHED_REM_RST) begin
        rem_reg <= rem_reg - 16'h0001;
      end
    end
  end

  assign active_o = (rem_reg != `SCHED_REM_RST);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_due_opens;
    (ce_i && !wr_i && tick_i && due && dur_reg != `SCHED_REM_RST) |=> active_o;
  endproperty
  a_due_opens: assert property (p_due_opens) else $error("due entry did not open");

  property p_window_len;
    (ce_i && !wr_i && tick_i && due) |=> (rem_reg == $past(dur_reg));
  endproperty
  a_window_len: assert property (p_window_len) else $error("window length wrong");

endmodule

// File: core/exercise_run_scheduler.sv
/*
  Exercise-run scheduler: sixteen timed entries that ask the engine
  sequencer to start and stop the set, on or off load.
  Assumes a one-minute tick with day and minute count on the same clock,
  and an engine sequencer that reports running and loaded state.
*/
// How it works
// - Sixteen entries are stored and each is checked against the calendar.
// - A setting picks a seven-day or twenty-eight-day repeat cycle.
// - A due entry requests a start; stop is requested when its run ends.
// - Each entry holds a start day, start minute and run length.
// - A setting decides whether scheduled runs are on load or off load.
// - In stop mode no start is requested after the next enabled clock edge.
// - In manual mode no start is requested for any due entry.
// - Manual running off load stays off load when an on-load entry fires.
// - Runs act only in auto mode without shutdown or trip alarms.
// - Entering auto during an open window requests a start at once.
// - When enabled, the external inhibit input suppresses scheduled runs.
// - Auto running off load goes on load for an on-load entry's window.
`timescale 1ns/1ps
`include "sched_consts.svh"

module exercise_run_scheduler
  import sched_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic entry_wr_i,
  input wire logic [`SCHED_IDX_W-1:0] entry_idx_i,
  input wire logic entry_valid_i,
  input wire logic [`SCHED_DAY_W-1:0] entry_day_i,
  input wire logic [`SCHED_MIN_W-1:0] entry_min_i,
  input wire logic [`SCHED_DUR_W-1:0] entry_dur_i,
  input wire logic cycle_28_i,
  input wire logic on_load_i,
  input wire logic inhibit_en_i,
  input wire logic inhibit_pin_i,
  input wire logic tick_i,
  input wire logic [`SCHED_DAY_W-1:0] cur_day_i,
  input wire logic [`SCHED_MIN_W-1:0] cur_min_i,
  input wire logic [1:0] mode_i,
  input wire logic shutdown_alarm_i,
  input wire logic trip_alarm_i,
  input wire logic set_running_i,
  input wire logic set_loaded_i,
  output logic start_req_o,
  output logic stop_req_o,
  output logic load_req_o,
  output logic window_o,
  output logic [`SCHED_ENTRIES-1:0] active_mask_o
);

  logic [`SCHED_ENTRIES-1:0] slot_active;
  logic [`SCHED_ENTRIES-1:0] mask_reg;
  logic window_reg;
  logic inhibit_q1;
  logic inhibit_q2;
  logic allowed;
  logic window_now;
  logic load_next;
  run_state_e state_reg;
  run_state_e state_next;

  // Entry store, one slot per index
  genvar gi;
  generate
    for (gi = 0; gi < `SCHED_ENTRIES; gi = gi + 1) begin : g_slot
      sched_entry u_entry (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .wr_i(entry_wr_i && (entry_idx_i == `SCHED_IDX_W'(gi))),
        .wr_valid_i(entry_valid_i),
        .wr_day_i(entry_day_i),
        .wr_min_i(entry_min_i),
        .wr_dur_i(entry_dur_i),
        .tick_i(tick_i),
        .cur_day_i(cur_day_i),
        .cur_min_i(cur_min_i),
        .cycle_28_i(cycle_28_i),
        .active_o(slot_active[gi])
      );
    end
  endgenerate

  // Inhibit pin comes from outside the clock domain
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      inhibit_q1 <= 1'b0;
      inhibit_q2 <= 1'b0;
    end else if (ce_i) begin
      inhibit_q1 <= inhibit_pin_i;
      inhibit_q2 <= inhibit_q1;
    end
  end

  assign window_now = |slot_active;

  // Gating: auto mode only, no alarms, no enabled inhibit
  assign allowed = (mode_i == MODE_AUTO) &&
                   !shutdown_alarm_i && !trip_alarm_i &&
                   !(inhibit_en_i && inhibit_q2);

  // The window runs in every mode, so a late move into auto still starts
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (window_now && allowed) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!window_now || !allowed) begin
          state_next = ST_STOP;
        end
      end
      ST_STOP: begin
        // A window that is still open and allowed again restarts at once
        if (window_now && allowed) begin
          state_next = ST_RUN;
        end else begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg <= ST_IDLE;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // Load request follows the configured choice only while we own the run
  assign load_next = (state_next == ST_RUN) && on_load_i;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      load_req_o <= 1'b0;
    end else if (ce_i) begin
      load_req_o <= load_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mask_reg <= `SCHED_MASK_RST;
      window_reg <= 1'b0;
    end else if (ce_i) begin
      mask_reg <= slot_active;
      window_reg <= window_now;
    end
  end

  assign start_req_o = (state_reg == ST_RUN);
  assign stop_req_o = (state_reg == ST_STOP);
  assign window_o = window_reg;
  assign active_mask_o = mask_reg;

  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_due_and_free;
    ce_i && window_now && allowed && !start_req_o;
  endsequence

  sequence s_run_ends;
    ce_i && start_req_o && !window_now;
  endsequence

  sequence s_stop_then_idle;
    stop_req_o && !start_req_o ##1 (!stop_req_o || !$past(ce_i));
  endsequence

  property p_stop_mode;
    (ce_i && mode_i == MODE_STOP) |=> !start_req_o;
  endproperty
  a_stop_mode: assert property (p_stop_mode) else $error("start in stop mode");

  property p_manual_mode;
    (ce_i && mode_i == MODE_MANUAL) |=> !start_req_o && !load_req_o;
  endproperty
  a_manual_mode: assert property (p_manual_mode) else $error("start in manual mode");

  property p_manual_load;
    (ce_i && mode_i == MODE_MANUAL && set_running_i && !set_loaded_i)
      |=> !load_req_o;
  endproperty
  a_manual_load: assert property (p_manual_load) else $error("manual load changed");

  property p_alarm_block;
    (ce_i && (shutdown_alarm_i || trip_alarm_i)) |=> !start_req_o;
  endproperty
  a_alarm_block: assert property (p_alarm_block) else $error("start under alarm");

  property p_inhibit;
    (ce_i && inhibit_en_i && inhibit_q2) |=> !start_req_o;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("start while inhibited");

  property p_start;
    s_due_and_free |=> start_req_o;
  endproperty
  a_start: assert property (p_start) else $error("due run not started");

  property p_late_auto;
    (ce_i && window_now && allowed && $past(mode_i) != MODE_AUTO && !start_req_o)
      |=> start_req_o;
  endproperty
  a_late_auto: assert property (p_late_auto) else $error("late auto not started");

  property p_run_end;
    s_run_ends |=> s_stop_then_idle;
  endproperty
  a_run_end: assert property (p_run_end) else $error("run end not stopped");

  property p_on_load;
    (start_req_o && $past(ce_i) && $past(on_load_i) && $past(state_next) == ST_RUN)
      |-> load_req_o;
  endproperty
  a_on_load: assert property (p_on_load) else $error("on-load run not loaded");

  property p_load_cfg;
    (ce_i && !on_load_i) |=> !load_req_o;
  endproperty
  a_load_cfg: assert property (p_load_cfg) else $error("off-load run loaded");

  property p_load_only_running;
    !start_req_o |-> !load_req_o;
  endproperty
  a_load_only_running: assert property (p_load_only_running) else $error("load without run");

  property p_mask;
    ce_i |=> (active_mask_o == $past(slot_active)) && (window_o == (|active_mask_o));
  endproperty
  a_mask: assert property (p_mask) else $error("status mask stale");

  property p_freeze;
    !ce_i |=> $stable(state_reg) && $stable(load_req_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved without enable");

endmodule

// File: testbench/engine_seq_model.sv
/*
  Behavioural engine sequencer that answers the scheduler's requests.
  Assumes the scheduler's start and load requests are levels on clk_i.
*/
`timescale 1ns/1ps

module engine_seq_model #(
  parameter int START_DLY = 3
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_req_i,
  input wire logic load_req_i,
  output logic set_running_o,
  output logic set_loaded_o
);
  logic [7:0] crank_reg;

  // Cranking takes START_DLY+1 cycles; dropping the request stops at once
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !start_req_i) begin
      crank_reg <= 8'h00;
      set_running_o <= 1'b0;
    end else if (crank_reg < 8'(START_DLY)) begin
      crank_reg <= crank_reg + 8'h01;
    end else begin
      set_running_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      set_loaded_o <= 1'b0;
    end else begin
      set_loaded_o <= set_running_o && load_req_i;
    end
  end
endmodule

// File: testbench/exercise_run_scheduler_tb_top.sv
/*
  Self-checking bench for the exercise-run scheduler.
  Assumes the design files under core/ and the sequencer model are compiled first.
*/
`timescale 1ns/1ps

module exercise_run_scheduler_tb_top
  import sched_pkg::*;
;
  logic clk, rst_b, ce, wr, valid, cyc28, onld, inh_en, inh_pin, tick, sd, trip;
  logic [3:0] idx;
  day_t day, cur_day;
  min_t mn, cur_min;
  dur_t dur;
  logic [1:0] mode;
  logic running, loaded, start, stop, load, win;
  logic [15:0] mask;
  int n_errors = 0;
  int total_checks = 0;

  exercise_run_scheduler dut (.clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .entry_wr_i(wr),
    .entry_idx_i(idx), .entry_valid_i(valid), .entry_day_i(day), .entry_min_i(mn),
    .entry_dur_i(dur), .cycle_28_i(cyc28), .on_load_i(onld), .inhibit_en_i(inh_en),
    .inhibit_pin_i(inh_pin), .tick_i(tick), .cur_day_i(cur_day), .cur_min_i(cur_min),
    .mode_i(mode), .shutdown_alarm_i(sd), .trip_alarm_i(trip), .set_running_i(running),
    .set_loaded_i(loaded), .start_req_o(start), .stop_req_o(stop), .load_req_o(load),
    .window_o(win), .active_mask_o(mask));

  engine_seq_model #(.START_DLY(3)) seq (.clk_i(clk), .rst_b_i(rst_b), .start_req_i(start),
    .load_req_i(load), .set_running_o(running), .set_loaded_o(loaded));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test;
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic put(input logic [3:0] i, input logic v, input day_t d, input min_t m,
                     input dur_t u);
    wr = 1'b1;
    idx = i;
    valid = v;
    day = d;
    mn = m;
    dur = u;
    step(1);
    wr = 1'b0;
  endtask

  // Calendar tick, returns two cycles after the tick edge
  task automatic tk(input day_t d, input min_t m);
    tick = 1'b1;
    cur_day = d;
    cur_min = m;
    step(1);
    tick = 1'b0;
    step(2);
  endtask

  task automatic s_run;
    put(4'hF, 1'b1, 5'h03, 11'h064, 16'h0002);
    tk(5'h03, 11'h063);
    chk("start_near", start, 16'h0000);
    tk(5'h04, 11'h064);
    chk("start_day", start, 16'h0000);
    tk(5'h03, 11'h064);
    chk("start_due", start, 16'h0001);
    chk("load_due", load, 16'h0001);
    chk("window", win, 16'h0001);
    chk("mask", mask, 16'h8000);
    tk(5'h03, 11'h065);
    chk("start_mid", start, 16'h0001);
    // Last tick done by hand: the stop pulse stands for one cycle only
    tick = 1'b1;
    cur_day = 5'h03;
    cur_min = 11'h066;
    step(1);
    tick = 1'b0;
    step(1);
    chk("start_end", start, 16'h0000);
    chk("stop_end", stop, 16'h0001);
    chk("load_end", load, 16'h0000);
    step(1);
    chk("stop_pulse", stop, 16'h0000);
  endtask

  task automatic s_cycle;
    put(4'h0, 1'b1, 5'h02, 11'h0C8, 16'h0001);
    tk(5'h09, 11'h0C8);
    chk("weekly_fold", start, 16'h0001);
    tk(5'h09, 11'h0C9);
    cyc28 = 1'b1;
    tk(5'h09, 11'h0C8);
    chk("cycle28_nofold", start, 16'h0000);
    tk(5'h02, 11'h0C8);
    chk("cycle28_due", start, 16'h0001);
    put(4'h0, 1'b0, 5'h02, 11'h0C8, 16'h0001);
    step(3);
    chk("entry_closed", start, 16'h0000);
    cyc28 = 1'b0;
  endtask

  task automatic s_modes;
    mode = MODE_STOP;
    put(4'h1, 1'b1, 5'h01, 11'h12C, 16'h0005);
    tk(5'h01, 11'h12C);
    chk("stop_mode", start, 16'h0000);
    chk("stop_window", win, 16'h0001);
    mode = MODE_MANUAL;
    step(3);
    chk("manual_mode", start, 16'h0000);
    chk("manual_load", load, 16'h0000);
    mode = MODE_AUTO;
    step(2);
    chk("auto_enter", start, 16'h0001);
    sd = 1'b1;
    step(3);
    chk("shutdown", start, 16'h0000);
    sd = 1'b0;
    step(2);
    chk("shutdown_clear", start, 16'h0001);
    onld = 1'b0;
    step(6);
    mode = MODE_MANUAL;
    step(2);
    chk("manual_offload", load, 16'h0000);
    mode = MODE_AUTO;
    onld = 1'b1;
    step(2);
    chk("manual_back", start, 16'h0001);
    trip = 1'b1;
    step(3);
    chk("trip", start, 16'h0000);
    trip = 1'b0;
    mode = 2'h3;
    step(3);
    chk("mode3", start, 16'h0000);
    mode = MODE_AUTO;
    put(4'h1, 1'b0, 5'h01, 11'h12C, 16'h0005);
    step(3);
  endtask

  task automatic s_inhibit;
    inh_en = 1'b1;
    inh_pin = 1'b1;
    put(4'h2, 1'b1, 5'h06, 11'h190, 16'h0003);
    tk(5'h06, 11'h190);
    chk("inhibited", start, 16'h0000);
    inh_pin = 1'b0;
    step(5);
    chk("inhibit_off", start, 16'h0001);
    inh_en = 1'b0;
    inh_pin = 1'b1;
    step(5);
    chk("inhibit_unused", start, 16'h0001);
    onld = 1'b0;
    step(3);
    chk("off_load", load, 16'h0000);
    onld = 1'b1;
    step(3);
    chk("on_load", load, 16'h0001);
    put(4'h2, 1'b0, 5'h06, 11'h190, 16'h0003);
    step(3);
  endtask

  // Enable low freezes the run, the entry and the ignored tick
  task automatic s_enable;
    put(4'h3, 1'b1, 5'h05, 11'h1F4, 16'h0002);
    tk(5'h05, 11'h1F4);
    chk("en_start", start, 16'h0001);
    ce = 1'b0;
    mode = MODE_STOP;
    tk(5'h05, 11'h1F5);
    chk("en_frozen", start, 16'h0001);
    chk("en_mask", mask, 16'h0008);
    ce = 1'b1;
    step(1);
    chk("en_resume", start, 16'h0000);
    chk("en_stop", stop, 16'h0001);
    mode = MODE_AUTO;
    put(4'h3, 1'b0, 5'h05, 11'h1F4, 16'h0002);
    step(3);
  endtask

  // Reset in mid-run drops the request and forgets every entry
  task automatic s_reset;
    put(4'h4, 1'b1, 5'h00, 11'h00A, 16'h0003);
    tk(5'h00, 11'h00A);
    chk("pre_reset", start, 16'h0001);
    rst_b = 1'b0;
    step(1);
    rst_b = 1'b1;
    step(1);
    chk("rst_start", start, 16'h0000);
    chk("rst_stop", stop, 16'h0000);
    chk("rst_load", load, 16'h0000);
    chk("rst_win", win, 16'h0000);
    chk("rst_mask", mask, 16'h0000);
    tk(5'h00, 11'h00A);
    chk("rst_entry", start, 16'h0000);
  endtask

  initial begin
    rst_b = 1'b0;
    {wr, valid, cyc28, inh_en, inh_pin, tick, sd, trip} = 8'h00;
    onld = 1'b1;
    ce = 1'b1;
    idx = 4'h0;
    day = 5'h00;
    mn = 11'h000;
    dur = 16'h0000;
    cur_day = 5'h00;
    cur_min = 11'h000;
    mode = MODE_AUTO;
    step(5);
    rst_b = 1'b1;
    step(1);
    chk("reset_start", start, 16'h0000);
    chk("reset_mask", mask, 16'h0000);
    s_run();
    s_cycle();
    s_modes();
    s_inhibit();
    s_enable();
    s_reset();
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule
